// ===== design/ssc_defines.vh
// Shared constants for the synchro check common select stage.
`ifndef SSC_DEFINES_VH
`define SSC_DEFINES_VH

`define SSC_CLK_HZ 125000000
`define SSC_HOLD_MS 45
`define SSC_BUSBLK_MS 1000
`define SSC_MS_DIV 1000

`define SSC_W 16
`define SSC_WT_W 8
`define SSC_IRQ_W 3

`define SSC_OFF_CTRL 8'h00
`define SSC_OFF_AUTO_ULIM 8'h04
`define SSC_OFF_AUTO_FLIM 8'h08
`define SSC_OFF_AUTO_ALIM 8'h0c
`define SSC_OFF_MAN_ULIM 8'h10
`define SSC_OFF_MAN_FLIM 8'h14
`define SSC_OFF_MAN_ALIM 8'h18
`define SSC_OFF_WEIGHT 8'h1c
`define SSC_OFF_STATUS 8'h20
`define SSC_OFF_IRQ_ST 8'h24
`define SSC_OFF_IRQ_MASK 8'h28
`define SSC_OFF_DIFF 8'h2c
`define SSC_OFF_ANGLE 8'h30

`define SSC_CTRL_CHOICE_LSB 0
`define SSC_CTRL_CHOICE_MSB 2
`define SSC_CTRL_BYP_AUTO 4
`define SSC_CTRL_BYP_MAN 5
`define SSC_CTRL_MASK 32'h00000037

`define SSC_CHOICE_L1N 3'h0
`define SSC_CHOICE_L2N 3'h1
`define SSC_CHOICE_L3N 3'h2
`define SSC_CHOICE_L1L2 3'h3
`define SSC_CHOICE_L2L3 3'h4
`define SSC_CHOICE_L3L1 3'h5

`define SSC_RST_CTRL 32'h00000000
`define SSC_RST_ULIM 16'h0100
`define SSC_RST_FLIM 16'h0010
`define SSC_RST_ALIM 16'h0200
`define SSC_RST_WEIGHT 24'h565555

`define SSC_IRQ_AUTO_CMD 0
`define SSC_IRQ_MAN_CMD 1
`define SSC_IRQ_BUS_CHG 2

`endif

// ===== design/ssc_path_eval.v
// One switching path: condition flags, release hold timer and command sequencing.
`timescale 1ns/1ps
module ssc_path_eval #(
  parameter W = 16,
  parameter CW = 24,
  parameter HOLD_CYC = 5625000
) (
  input wire clk,
  input wire rst,
  input wire blocked,
  input wire bypass,
  input wire [W-1:0] u_diff,
  input wire [W-1:0] f_diff,
  input wire [W-1:0] a_diff,
  input wire [W-1:0] u_lim,
  input wire [W-1:0] f_lim,
  input wire [W-1:0] a_lim,
  input wire request,
  input wire cancel,
  output reg release_r,
  output wire in_progress,
  output wire command,
  output reg voltage_ok_r,
  output reg freq_ok_r,
  output reg angle_ok_r
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_CMD = 3'b100;
  localparam integer HOLD_M1 = HOLD_CYC - 1;
  localparam [CW-1:0] HOLD_LAST = HOLD_M1[CW-1:0];

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [CW-1:0] hold_r;
  wire all_ok;

  assign all_ok = voltage_ok_r & freq_ok_r & angle_ok_r;
  assign in_progress = state_r[1] | state_r[2];
  assign command = state_r[2];

  always @(posedge clk) begin
    if (rst) begin
      voltage_ok_r <= 1'b0;
      freq_ok_r <= 1'b0;
      angle_ok_r <= 1'b0;
    end else begin
      voltage_ok_r <= (u_diff <= u_lim);
      freq_ok_r <= (f_diff <= f_lim);
      angle_ok_r <= (a_diff <= a_lim);
    end
  end

  always @(posedge clk) begin
    if (rst || blocked || !all_ok) begin
      hold_r <= {CW{1'b0}};
    end else if (hold_r != HOLD_LAST) begin
      hold_r <= hold_r + 1'b1;
    end
  end

  always @(posedge clk) begin
    if (rst || blocked) begin
      release_r <= 1'b0;
    end else if (bypass) begin
      release_r <= 1'b1;
    end else begin
      release_r <= all_ok && (hold_r == HOLD_LAST);
    end
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (request && !blocked && !cancel) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (cancel || blocked) begin
          state_nxt = ST_IDLE;
        end else if (release_r) begin
          state_nxt = ST_CMD;
        end
      end
      ST_CMD: begin
        if (cancel || blocked || !request || (!bypass && !release_r)) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end
endmodule

// ===== design/ssc_common_select_stage.v
// Synchro check front end: voltage selection, differences, blocking and two paths.
//
// Overview of operation
// - A line voltage transformer supervision block disables operation.
// - The supervision block of the currently selected bus section disables operation.
// - Bus two is evaluated when the bus select input is high, bus one otherwise.
// - A change of active bus section blocks both paths for 1000 ms.
// - A six-valued choice selects the line voltage, defaulting to the first phase to neutral.
// - Magnitude, frequency and angle differences are computed and magnitudes forwarded.
// - Automatic and manual requests each start their own independent procedure.
// - Each cancel input stops only its own running procedure.
// - Each path drives release, in progress and three condition ok flags.
// - Line frequency is a weighted sum of the three phase frequencies.
// - The combined command is the OR of the automatic and manual commands.
// - Command levels are not in any readable register, but their rising edges set interrupt status bits.
// - Outside bypass, release needs all three conditions held continuously for 45 ms.
// - In bypass a close request passes straight through as a command.
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
`include "ssc_defines.vh"
module ssc_common_select_stage #(
  parameter W = `SSC_W,
  parameter HOLD_CYC = `SSC_CLK_HZ / `SSC_MS_DIV * `SSC_HOLD_MS,
  parameter BUSBLK_CYC = `SSC_CLK_HZ / `SSC_MS_DIV * `SSC_BUSBLK_MS
) (
  input wire clk,
  input wire rst,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire irq,
  input wire function_block_in,
  input wire bus_two_select_in,
  input wire line_vt_block_in,
  input wire bus_one_vt_block_in,
  input wire bus_two_vt_block_in,
  input wire auto_switch_request,
  input wire auto_cancel,
  input wire manual_switch_request,
  input wire manual_cancel,
  input wire [6*W-1:0] line_phasor_set_mag,
  input wire [6*W-1:0] line_phasor_set_ang,
  input wire [3*W-1:0] line_phasor_set_freq,
  input wire [W-1:0] bus_one_phasor_mag,
  input wire [W-1:0] bus_one_phasor_ang,
  input wire [W-1:0] bus_one_phasor_freq,
  input wire [W-1:0] bus_two_phasor_mag,
  input wire [W-1:0] bus_two_phasor_ang,
  input wire [W-1:0] bus_two_phasor_freq,
  output reg [W-1:0] u_diff_r,
  output reg [W-1:0] f_diff_r,
  output reg [W-1:0] angle_difference_r,
  output reg [W-1:0] u_line_r,
  output reg [W-1:0] u_bus_r,
  output wire auto_release,
  output wire auto_in_progress,
  output wire auto_switch_command,
  output wire auto_voltage_ok,
  output wire auto_freq_ok,
  output wire auto_angle_ok,
  output wire manual_release,
  output wire manual_in_progress,
  output wire manual_switch_command,
  output wire manual_voltage_ok,
  output wire manual_freq_ok,
  output wire manual_angle_ok,
  output wire combined_switch_command
);
  localparam HOLD_W = 24;
  localparam BLK_W = 28;
  localparam integer BUSBLK_M1 = BUSBLK_CYC - 1;
  localparam [BLK_W-1:0] BUSBLK_LAST = BUSBLK_M1[BLK_W-1:0];
  localparam SUM_W = W + `SSC_WT_W + 2;
  reg [31:0] ctrl_r;
  reg [W-1:0] auto_ulim_r;
  reg [W-1:0] auto_flim_r;
  reg [W-1:0] auto_alim_r;
  reg [W-1:0] man_ulim_r;
  reg [W-1:0] man_flim_r;
  reg [W-1:0] man_alim_r;
  reg [3*`SSC_WT_W-1:0] weight_r;
  reg [`SSC_IRQ_W-1:0] irq_st_r;
  reg [`SSC_IRQ_W-1:0] irq_st_nxt;
  reg [`SSC_IRQ_W-1:0] irq_mask_r;
  reg bus_sel_prev_r;
  reg dyn_block_r;
  reg [BLK_W-1:0] dyn_cnt_r;
  reg [1:0] cmd_prev_r;
  reg [2:0] choice;
  reg [W-1:0] sel_mag;
  reg [W-1:0] sel_ang;
  reg [SUM_W-1:0] freq_sum;
  reg [W-1:0] line_freq;
  reg map_hit;
  wire [W-1:0] bus_mag;
  wire [W-1:0] bus_ang;
  wire [W-1:0] bus_freq;
  wire [W-1:0] ang_raw;
  wire bus_change;
  wire blocked;
  wire wr_en;
  wire rd_en;
  wire [1:0] req_w;
  wire [1:0] cancel_w;
  wire [1:0] bypass_w;
  wire [2*W-1:0] ulim_w;
  wire [2*W-1:0] flim_w;
  wire [2*W-1:0] alim_w;
  wire [1:0] rel_w;
  wire [1:0] prog_w;
  wire [1:0] cmd_w;
  wire [1:0] uok_w;
  wire [1:0] fok_w;
  wire [1:0] aok_w;
  wire [`SSC_IRQ_W-1:0] irq_ev;

  function [W-1:0] abs_diff;
    input [W-1:0] a;
    input [W-1:0] b;
    begin
      abs_diff = (a > b) ? (a - b) : (b - a);
    end
  endfunction

  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign pslverr = psel & penable & ~map_hit;

  assign bus_mag = bus_two_select_in ? bus_two_phasor_mag : bus_one_phasor_mag;
  assign bus_ang = bus_two_select_in ? bus_two_phasor_ang : bus_one_phasor_ang;
  assign bus_freq = bus_two_select_in ? bus_two_phasor_freq : bus_one_phasor_freq;

  // function block, line supervision, dynamic bus change block, selected bus supervision.
  assign blocked = function_block_in | line_vt_block_in | dyn_block_r |
                   (bus_two_select_in ? bus_two_vt_block_in : bus_one_vt_block_in);

  always @* begin
    choice = ctrl_r[`SSC_CTRL_CHOICE_MSB:`SSC_CTRL_CHOICE_LSB];
    case (choice)
      `SSC_CHOICE_L2N: begin
        sel_mag = line_phasor_set_mag[2*W-1:W];
        sel_ang = line_phasor_set_ang[2*W-1:W];
      end
      `SSC_CHOICE_L3N: begin
        sel_mag = line_phasor_set_mag[3*W-1:2*W];
        sel_ang = line_phasor_set_ang[3*W-1:2*W];
      end
      `SSC_CHOICE_L1L2: begin
        sel_mag = line_phasor_set_mag[4*W-1:3*W];
        sel_ang = line_phasor_set_ang[4*W-1:3*W];
      end
      `SSC_CHOICE_L2L3: begin
        sel_mag = line_phasor_set_mag[5*W-1:4*W];
        sel_ang = line_phasor_set_ang[5*W-1:4*W];
      end
      `SSC_CHOICE_L3L1: begin
        sel_mag = line_phasor_set_mag[6*W-1:5*W];
        sel_ang = line_phasor_set_ang[6*W-1:5*W];
      end
      default: begin
        sel_mag = line_phasor_set_mag[W-1:0];
        sel_ang = line_phasor_set_ang[W-1:0];
      end
    endcase
  end

  // weighted line frequency, weights in units of one 256th.
  always @* begin
    freq_sum = line_phasor_set_freq[W-1:0] * weight_r[`SSC_WT_W-1:0]
             + line_phasor_set_freq[2*W-1:W] * weight_r[2*`SSC_WT_W-1:`SSC_WT_W]
             + line_phasor_set_freq[3*W-1:2*W] * weight_r[3*`SSC_WT_W-1:2*`SSC_WT_W];
    line_freq = freq_sum[W+`SSC_WT_W-1:`SSC_WT_W];
  end

  // Angles wrap modulo full turn, so the signed difference is folded.
  assign ang_raw = sel_ang - bus_ang;

  always @(posedge clk) begin
    if (rst) begin
      u_diff_r <= {W{1'b0}};
      f_diff_r <= {W{1'b0}};
      angle_difference_r <= {W{1'b0}};
      u_line_r <= {W{1'b0}};
      u_bus_r <= {W{1'b0}};
    end else begin
      u_diff_r <= abs_diff(sel_mag, bus_mag);
      f_diff_r <= abs_diff(line_freq, bus_freq);
      angle_difference_r <= ang_raw[W-1] ? ({W{1'b0}} - ang_raw) : ang_raw;
      u_line_r <= sel_mag;
      u_bus_r <= bus_mag;
    end
  end

  // dynamic block after a bus section change.
  assign bus_change = bus_two_select_in ^ bus_sel_prev_r;
  always @(posedge clk) begin
    if (rst) begin
      bus_sel_prev_r <= bus_two_select_in;
      dyn_block_r <= 1'b0;
      dyn_cnt_r <= {BLK_W{1'b0}};
    end else begin
      bus_sel_prev_r <= bus_two_select_in;
      if (bus_change) begin
        dyn_block_r <= 1'b1;
        dyn_cnt_r <= {BLK_W{1'b0}};
      end else if (dyn_block_r) begin
        if (dyn_cnt_r == BUSBLK_LAST) begin
          dyn_block_r <= 1'b0;
        end
        dyn_cnt_r <= dyn_cnt_r + 1'b1;
      end
    end
  end

  assign req_w = {manual_switch_request, auto_switch_request};
  assign cancel_w = {manual_cancel, auto_cancel};
  assign bypass_w = {ctrl_r[`SSC_CTRL_BYP_MAN], ctrl_r[`SSC_CTRL_BYP_AUTO]};
  assign ulim_w = {man_ulim_r, auto_ulim_r};
  assign flim_w = {man_flim_r, auto_flim_r};
  assign alim_w = {man_alim_r, auto_alim_r};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_path
      ssc_path_eval #(
        .W(W),
        .CW(HOLD_W),
        .HOLD_CYC(HOLD_CYC)
      ) u_path (
        .clk(clk),
        .rst(rst),
        .blocked(blocked),
        .bypass(bypass_w[gi]),
        .u_diff(u_diff_r),
        .f_diff(f_diff_r),
        .a_diff(angle_difference_r),
        .u_lim(ulim_w[gi*W +: W]),
        .f_lim(flim_w[gi*W +: W]),
        .a_lim(alim_w[gi*W +: W]),
        .request(req_w[gi]),
        .cancel(cancel_w[gi]),
        .release_r(rel_w[gi]),
        .in_progress(prog_w[gi]),
        .command(cmd_w[gi]),
        .voltage_ok_r(uok_w[gi]),
        .freq_ok_r(fok_w[gi]),
        .angle_ok_r(aok_w[gi])
      );
    end
  endgenerate

  assign auto_release = rel_w[0];
  assign auto_in_progress = prog_w[0];
  assign auto_switch_command = cmd_w[0];
  assign auto_voltage_ok = uok_w[0];
  assign auto_freq_ok = fok_w[0];
  assign auto_angle_ok = aok_w[0];
  assign manual_release = rel_w[1];
  assign manual_in_progress = prog_w[1];
  assign manual_switch_command = cmd_w[1];
  assign manual_voltage_ok = uok_w[1];
  assign manual_freq_ok = fok_w[1];
  assign manual_angle_ok = aok_w[1];
  assign combined_switch_command = cmd_w[0] | cmd_w[1];

  // Interrupt events: rising commands and bus section changes.
  assign irq_ev = {bus_change, cmd_w & ~cmd_prev_r};
  assign irq = |(irq_st_r & irq_mask_r);

  always @* begin
    irq_st_nxt = irq_st_r;
    if (rd_en && paddr == `SSC_OFF_IRQ_ST) begin
      irq_st_nxt = {`SSC_IRQ_W{1'b0}};
    end
    irq_st_nxt = irq_st_nxt | irq_ev;
  end

  always @(posedge clk) begin
    if (rst) begin
      ctrl_r <= `SSC_RST_CTRL;
      auto_ulim_r <= `SSC_RST_ULIM;
      auto_flim_r <= `SSC_RST_FLIM;
      auto_alim_r <= `SSC_RST_ALIM;
      man_ulim_r <= `SSC_RST_ULIM;
      man_flim_r <= `SSC_RST_FLIM;
      man_alim_r <= `SSC_RST_ALIM;
      weight_r <= `SSC_RST_WEIGHT;
      irq_mask_r <= {`SSC_IRQ_W{1'b0}};
      irq_st_r <= {`SSC_IRQ_W{1'b0}};
      cmd_prev_r <= 2'h0;
    end else begin
      irq_st_r <= irq_st_nxt;
      cmd_prev_r <= cmd_w;
      if (wr_en) begin
        case (paddr)
          `SSC_OFF_CTRL: ctrl_r <= pwdata & `SSC_CTRL_MASK;
          `SSC_OFF_AUTO_ULIM: auto_ulim_r <= pwdata[W-1:0];
          `SSC_OFF_AUTO_FLIM: auto_flim_r <= pwdata[W-1:0];
          `SSC_OFF_AUTO_ALIM: auto_alim_r <= pwdata[W-1:0];
          `SSC_OFF_MAN_ULIM: man_ulim_r <= pwdata[W-1:0];
          `SSC_OFF_MAN_FLIM: man_flim_r <= pwdata[W-1:0];
          `SSC_OFF_MAN_ALIM: man_alim_r <= pwdata[W-1:0];
          `SSC_OFF_WEIGHT: weight_r <= pwdata[3*`SSC_WT_W-1:0];
          `SSC_OFF_IRQ_MASK: irq_mask_r <= pwdata[`SSC_IRQ_W-1:0];
          default: begin
          end
        endcase
      end
    end
  end

  // command pins stay out of the readable status.
  always @* begin
    map_hit = 1'b1;
    prdata = 32'h00000000;
    case (paddr)
      `SSC_OFF_CTRL: prdata = ctrl_r;
      `SSC_OFF_AUTO_ULIM: prdata[W-1:0] = auto_ulim_r;
      `SSC_OFF_AUTO_FLIM: prdata[W-1:0] = auto_flim_r;
      `SSC_OFF_AUTO_ALIM: prdata[W-1:0] = auto_alim_r;
      `SSC_OFF_MAN_ULIM: prdata[W-1:0] = man_ulim_r;
      `SSC_OFF_MAN_FLIM: prdata[W-1:0] = man_flim_r;
      `SSC_OFF_MAN_ALIM: prdata[W-1:0] = man_alim_r;
      `SSC_OFF_WEIGHT: prdata[3*`SSC_WT_W-1:0] = weight_r;
      `SSC_OFF_STATUS: prdata[7:0] = {prog_w, rel_w, dyn_block_r, bus_two_select_in,
                                      blocked, 1'b0};
      `SSC_OFF_IRQ_ST: prdata[`SSC_IRQ_W-1:0] = irq_st_r;
      `SSC_OFF_IRQ_MASK: prdata[`SSC_IRQ_W-1:0] = irq_mask_r;
      `SSC_OFF_DIFF: prdata = {f_diff_r, u_diff_r};
      `SSC_OFF_ANGLE: prdata[W-1:0] = angle_difference_r;
      default: map_hit = 1'b0;
    endcase
  end
endmodule

// ===== bench/ssc_props.sv
// Concurrent checks on the ports of the synchro check common select stage.
`timescale 1ns/1ps
module ssc_props #(
  parameter int HOLD_CYC = 5625000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic function_block_in,
  input wire logic bus_two_select_in,
  input wire logic line_vt_block_in,
  input wire logic bus_one_vt_block_in,
  input wire logic bus_two_vt_block_in,
  input wire logic auto_cancel,
  input wire logic [15:0] bus_one_phasor_mag,
  input wire logic [15:0] bus_two_phasor_mag,
  input wire logic [15:0] u_bus_r,
  input wire logic auto_release,
  input wire logic auto_in_progress,
  input wire logic auto_switch_command,
  input wire logic auto_voltage_ok,
  input wire logic auto_freq_ok,
  input wire logic auto_angle_ok,
  input wire logic manual_release,
  input wire logic manual_in_progress,
  input wire logic manual_switch_command,
  input wire logic combined_switch_command
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Counts consecutive cycles with all three automatic conditions met.
  int ok_cnt_r;
  always @(posedge clk) begin
    if (rst || !(auto_voltage_ok && auto_freq_ok && auto_angle_ok)) begin
      ok_cnt_r <= 0;
    end else begin
      ok_cnt_r <= ok_cnt_r + 1;
    end
  end

  a_block_idle: assert property (
    function_block_in [*3] |-> !auto_release && !auto_in_progress && !combined_switch_command)
    else $error("function block did not silence the paths");
  a_line_vt_idle: assert property (
    line_vt_block_in [*3] |-> !auto_in_progress && !manual_in_progress && !combined_switch_command)
    else $error("line supervision block did not stop the paths");
  a_bus_vt_idle: assert property (
    (bus_two_select_in ? bus_two_vt_block_in : bus_one_vt_block_in) [*3]
    |-> !auto_in_progress && !manual_in_progress)
    else $error("selected bus supervision block did not stop the paths");
  a_bus_mag_sel: assert property (
    !$past(rst) && !$past(rst, 2)
    |-> u_bus_r == $past(bus_two_select_in ? bus_two_phasor_mag : bus_one_phasor_mag))
    else $error("bus magnitude does not follow the selected section");
  a_bus_chg_quiet: assert property (
    $changed(bus_two_select_in)
    |-> ##3 (!auto_release && !manual_release && !combined_switch_command) [*8])
    else $error("release or command during bus change block");
  a_cancel_stop: assert property (
    auto_cancel |=> !auto_in_progress && !auto_switch_command)
    else $error("automatic cancel did not stop the procedure");
  a_cmd_or: assert property (
    combined_switch_command == (auto_switch_command || manual_switch_command))
    else $error("combined command is not the OR of both commands");
  a_rel_hold_time: assert property (
    $rose(auto_release) |-> ok_cnt_r >= HOLD_CYC)
    else $error("automatic release before the hold time");
  a_cmd_after_rel: assert property (
    $rose(auto_switch_command) |-> $past(auto_release) && $past(auto_in_progress))
    else $error("automatic command without release in progress");
endmodule

// ===== bench/ssc_partner_model.sv
// Model of the user logic and reclosing function that raise and cancel requests.
`timescale 1ns/1ps
module ssc_partner_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic want_auto,
  input wire logic want_man,
  input wire logic stop_auto,
  input wire logic stop_man,
  output logic auto_switch_request = 1'b0,
  output logic auto_cancel = 1'b0,
  output logic manual_switch_request = 1'b0,
  output logic manual_cancel = 1'b0
);
  always @(posedge clk) begin
    auto_switch_request <= !rst && want_auto;
    manual_switch_request <= !rst && want_man;
    auto_cancel <= !rst && stop_auto;
    manual_cancel <= !rst && stop_man;
  end
endmodule

// ===== bench/ssc_common_select_stage_tb.sv
// Testbench of the synchro check common select stage.
`timescale 1ns/1ps
`include "ssc_defines.vh"
module ssc_common_select_stage_tb;
  localparam int HOLD = 20;
  localparam int BLK = 50;
  logic clk = 0;
  logic rst = 1;
  logic [7:0] paddr = 0;
  logic psel = 0, penable = 0, pwrite = 0, err_q;
  logic [31:0] pwdata = 0, rd_q;
  wire [31:0] prdata;
  wire pready, pslverr, irq;
  logic function_block_in = 0, bus_two_select_in = 0, line_vt_block_in = 0;
  logic bus_one_vt_block_in = 0, bus_two_vt_block_in = 0;
  logic want_auto = 0, want_man = 0, stop_auto = 0, stop_man = 0;
  wire auto_switch_request, auto_cancel, manual_switch_request, manual_cancel;
  logic [95:0] line_phasor_set_mag = {16'h0f00, 16'h0e00, 16'h0d00, 16'h0c00, 16'h0b00, 16'h0a00};
  logic [95:0] line_phasor_set_ang = {6{16'h0100}};
  logic [47:0] line_phasor_set_freq = {3{16'h03e8}};
  logic [15:0] bus_one_phasor_mag = 16'h0980, bus_one_phasor_ang = 16'hff80;
  logic [15:0] bus_one_phasor_freq = 16'h03e0, bus_two_phasor_mag = 16'h09c0;
  logic [15:0] bus_two_phasor_ang = 16'h0100, bus_two_phasor_freq = 16'h03e8;
  wire [15:0] u_diff_r, f_diff_r, angle_difference_r, u_line_r, u_bus_r;
  wire auto_release, auto_in_progress, auto_switch_command, auto_voltage_ok;
  wire auto_freq_ok, auto_angle_ok, manual_release, manual_in_progress;
  wire manual_switch_command, manual_voltage_ok, manual_freq_ok, manual_angle_ok;
  wire combined_switch_command;
  int n_mismatch = 0;
  int cmp_count = 0;

  ssc_common_select_stage #(.HOLD_CYC(HOLD), .BUSBLK_CYC(BLK)) ssc_common_select_stage_i (.*);
  ssc_partner_model ssc_partner_model_i (.*);

  always #4 clk = ~clk;

  // Read data is taken at the edge that completes the access phase.
  always @(posedge clk) begin
    if (psel && penable && pready) begin
      rd_q <= prdata;
      err_q <= pslverr;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(rd_q, e);
  endtask

  task automatic wcmd(input bit man, input int lim);
    int n;
    n = 0;
    while ((man ? manual_switch_command : auto_switch_command) !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(man ? manual_switch_command : auto_switch_command, 1);
  endtask

  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    cyc(5);
    rst <= 0;
    cyc(1);
    rd(`SSC_OFF_CTRL, 32'h0);
    rd(`SSC_OFF_MAN_ULIM, 32'h100);
    rd(`SSC_OFF_AUTO_FLIM, 32'h10);
    rd(`SSC_OFF_MAN_ALIM, 32'h200);
    rd(`SSC_OFF_WEIGHT, 32'h565555);
    rd(8'h3c, 32'h0);
    chk(err_q, 1);
    done("reset");
    for (int c = 0; c < 6; c++) begin
      apb(1, `SSC_OFF_CTRL, c);
      cyc(2);
      chk(u_line_r, 16'h0a00 + 16'h0100 * c);
    end
    bus_two_select_in <= 1;
    cyc(3);
    chk(u_bus_r, 16'h09c0);
    chk(irq, 0);
    rd(`SSC_OFF_IRQ_ST, 32'h4);
    rd(`SSC_OFF_IRQ_ST, 32'h0);
    apb(1, `SSC_OFF_IRQ_MASK, 32'h4);
    bus_two_select_in <= 0;
    cyc(4);
    chk(irq, 1);
    rd(`SSC_OFF_IRQ_ST, 32'h4);
    chk(irq, 0);
    done("select");
    apb(1, `SSC_OFF_CTRL, 32'h0);
    cyc(3);
    chk(u_diff_r, 16'h0080);
    chk(angle_difference_r, 16'h0180);
    chk(f_diff_r, 16'h0008);
    rd(`SSC_OFF_DIFF, 32'h00080080);
    rd(`SSC_OFF_ANGLE, 32'h00000180);
    apb(1, `SSC_OFF_WEIGHT, 32'h008080);
    line_phasor_set_freq <= {16'h03e8, 16'h0500, 16'h0400};
    cyc(3);
    chk(f_diff_r, 16'h00a0);
    apb(1, `SSC_OFF_WEIGHT, 32'h565555);
    line_phasor_set_freq <= {3{16'h03e8}};
    done("difference");
    cyc(BLK);
    chk({auto_voltage_ok, auto_freq_ok, auto_angle_ok}, 3'b111);
    want_auto <= 1;
    wcmd(0, HOLD + 10);
    chk(auto_in_progress, 1);
    chk(combined_switch_command, 1);
    chk(manual_in_progress, 0);
    rd(`SSC_OFF_STATUS, 32'h00000070);
    for (int k = 0; k < 4; k++) begin
      {function_block_in, line_vt_block_in, bus_one_vt_block_in, bus_two_vt_block_in} <= 4'h8 >> k;
      cyc(4);
      chk(auto_switch_command, k == 3);
      chk(auto_release, k == 3);
      {function_block_in, line_vt_block_in, bus_one_vt_block_in, bus_two_vt_block_in} <= 4'h0;
      wcmd(0, HOLD + 10);
    end
    done("block");
    bus_two_select_in <= 1;
    cyc(4);
    chk(auto_switch_command, 0);
    cyc(BLK - 10);
    chk(auto_release, 0);
    wcmd(0, HOLD + 30);
    done("bus change");
    want_auto <= 0;
    stop_auto <= 1;
    cyc(1);
    stop_auto <= 0;
    cyc(3);
    chk(auto_in_progress, 0);
    chk(auto_switch_command, 0);
    done("cancel");
    apb(1, `SSC_OFF_MAN_ULIM, 32'h0);
    cyc(3);
    chk(manual_voltage_ok, 0);
    chk(auto_voltage_ok, 1);
    chk({manual_freq_ok, manual_angle_ok}, 2'b11);
    apb(1, `SSC_OFF_CTRL, 32'h20);
    want_man <= 1;
    wcmd(1, 8);
    chk(manual_release, 1);
    chk(combined_switch_command, 1);
    chk(auto_in_progress, 0);
    rd(`SSC_OFF_IRQ_ST, 32'h7);
    want_man <= 0;
    stop_man <= 1;
    cyc(1);
    stop_man <= 0;
    cyc(3);
    chk(manual_in_progress, 0);
    done("bypass");
    print_verdict;
  end

  initial begin
    cyc(3000);
    n_mismatch++;
    print_verdict;
  end
endmodule

bind ssc_common_select_stage ssc_props #(.HOLD_CYC(HOLD_CYC)) ssc_props_i (.*);
